// [bst_pkg.sv]
// shared types, opcodes and constants for the boundary scan port
package bst_pkg;

   // tap controller states, 4-bit encoding covering all sixteen
   typedef enum logic [3:0] {
      ST_EX2_DR  = 4'h0,
      ST_EX1_DR  = 4'h1,
      ST_SH_DR   = 4'h2,
      ST_PA_DR   = 4'h3,
      ST_SEL_IR  = 4'h4,
      ST_UPD_DR  = 4'h5,
      ST_CAP_DR  = 4'h6,
      ST_SEL_DR  = 4'h7,
      ST_EX2_IR  = 4'h8,
      ST_EX1_IR  = 4'h9,
      ST_SH_IR   = 4'ha,
      ST_PA_IR   = 4'hb,
      ST_RTI     = 4'hc,
      ST_UPD_IR  = 4'hd,
      ST_CAP_IR  = 4'he,
      ST_TLR     = 4'hf
   } bst_state_t;

   typedef enum logic [1:0] {
      DR_BYP = 2'h0,
      DR_ID  = 2'h1,
      DR_BSR = 2'h2
   } bst_dr_t;

   // pad override mode carried from the scan side to the core side
   typedef struct packed {
      logic hiz;
      logic drive;
   } bst_mode_t;

   localparam int          IR_W       = 8;
   localparam int          ID_W       = 32;
   localparam int          ID_VER_W   = 4;
   localparam int          ID_PART_W  = 16;
   localparam int          ID_MFR_W   = 11;
   localparam logic        ID_MARKER  = 1'h1;

   localparam logic [7:0]  OP_EXTEST  = 8'h00;
   localparam logic [7:0]  OP_SAMPLE  = 8'h01;
   localparam logic [7:0]  OP_CLAMP   = 8'h05;
   localparam logic [7:0]  OP_HIGHZ   = 8'h07;
   localparam logic [7:0]  OP_USER    = 8'h0e;
   localparam logic [7:0]  OP_IDCODE  = 8'h0f;
   localparam logic [7:0]  OP_BYPASS  = 8'hff;
   localparam logic [7:0]  IR_CAPTURE = 8'h01;

   localparam int          CELLS_PER_IO = 3;
   localparam int          CELL_IN      = 0;
   localparam int          CELL_OUT     = 1;
   localparam int          CELL_OE      = 2;

   // pull-up enables for tms, tdi and trst, in that order
   localparam logic [2:0]  PULLUP_ALL   = 3'h7;

   // unassigned codes, and those with no register of their own, pick bypass
   function automatic bst_dr_t dr_select(input logic [7:0] op);
      case (op)
         OP_EXTEST, OP_SAMPLE: dr_select = DR_BSR;
         OP_IDCODE:            dr_select = DR_ID;
         default:              dr_select = DR_BYP;
      endcase
   endfunction : dr_select

   function automatic bst_mode_t op_mode(input logic [7:0] op);
      op_mode.hiz   = (op == OP_HIGHZ);
      op_mode.drive = (op == OP_EXTEST) || (op == OP_CLAMP);
   endfunction : op_mode

endpackage : bst_pkg

// [bst_sync2.sv]
// two flip-flop level synchroniser, any width
`timescale 1ns/1ps
module bst_sync2 #(
   parameter int W = 1
) (
   input  logic         i_clk,
   input  logic         i_rst_n,
   input  logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end

   assign o_q = sync_q;
endmodule : bst_sync2

// [bst_bscell.sv]
// one boundary scan cell: capture/shift stage and update latch
`timescale 1ns/1ps
module bst_bscell (
   input  logic i_tck,
   input  logic i_rst_n,
   input  logic i_si,
   input  logic i_pi,
   input  logic i_capture,
   input  logic i_shift,
   input  logic i_update,
   output logic o_so,
   output logic o_po
);
   logic sr_q;
   logic upd_q;

   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sr_q <= 1'h0;
      end else if (i_capture) begin
         sr_q <= i_pi;
      end else if (i_shift) begin
         sr_q <= i_si;
      end
   end

   // falling edge keeps the pad value steady while shifting on rising
   always_ff @(negedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         upd_q <= 1'h0;
      end else if (i_update) begin
         upd_q <= sr_q;
      end
   end

   assign o_so = sr_q;
   assign o_po = upd_q;
endmodule : bst_bscell

// [bst_tap_top.sv]
// boundary scan test access port with pad override logic
`timescale 1ns/1ps
// How it works
// - supports extest, sample/preload, bypass and idcode instructions.
// - five dedicated pins: tck, tdi, tdo, tms and trst.
// - tms, tdi and trst carry pull-ups so undriven reads high.
// - controller is a 4-bit encoded machine covering sixteen states.
// - transitions follow tms sampled on rising tck; host keeps tms valid.
// - power-up puts controller in test-logic-reset with no tck needed.
// - five rising edges with tms high reach test-logic-reset.
// - trst low forces test-logic-reset asynchronously.
// - only bypass, identification and boundary registers exist.
// - bypass is the path whenever no other register is addressed.
// - 32-bit id: marker bit, manufacturer, part, version.
// - three cells per pad: input, output, enable; serial and parallel.
// - cells form one chain from tdi to tdo.
// - cell parallel sides sit between core and pad buffer.
// - opcodes 00,01,05,07,0e,0f,ff as listed.
// - unprogrammed: pads untouched by sample, chain still shifts.
module bst_tap_top #(
   parameter int          N_IO       = 8,
   parameter logic [3:0]  ID_VERSION = 4'h1,    // arbitrary value
   parameter logic [15:0] ID_PART    = 16'h1234, // arbitrary value
   parameter logic [10:0] ID_MFR     = 11'h2a5  // arbitrary value
) (
   input  logic            i_clk,
   input  logic            i_resetn,
   input  logic            i_tck,
   input  logic            i_tms,
   input  logic            i_tdi,
   input  logic            i_trst_n,
   output logic            o_tdo,
   output logic            o_tdo_oe,
   output logic [2:0]      o_pullup_en,
   input  logic            i_programmed,
   input  logic [N_IO-1:0] i_core_o,
   input  logic [N_IO-1:0] i_core_oe,
   output logic [N_IO-1:0] o_core_i,
   input  logic [N_IO-1:0] i_pad_i,
   output logic [N_IO-1:0] o_pad_o,
   output logic [N_IO-1:0] o_pad_oe
);
   localparam int NC = N_IO * bst_pkg::CELLS_PER_IO;
   logic                  tck_rst_raw_n;
   logic [1:0]            tck_rst_q;
   logic                  tck_rst_n;
   logic [1:0]            clk_rst_q;
   logic                  clk_rst_n;
   bst_pkg::bst_state_t   st_q;
   bst_pkg::bst_state_t   st_d;
   logic [7:0]            ir_sr_q;
   logic [7:0]            ir_q;
   bst_pkg::bst_mode_t    mode_q;
   bst_pkg::bst_dr_t      dr_sel;
   logic                  byp_q;
   logic [31:0]           id_sr_q;
   logic [31:0]           id_value;
   logic                  dr_out;
   logic                  tdo_q;
   logic                  tdo_oe_q;
   logic [NC:0]           chain;
   logic [NC-1:0]         cell_pi;
   logic [NC-1:0]         cell_po;
   logic                  cap_bsr;
   logic                  sh_bsr;
   logic                  upd_bsr;
   logic [3*N_IO:0]       pi_t;
   logic [NC+1:0]         upd_c;
   logic [NC-1:0]         upd_cells_c;
   bst_pkg::bst_mode_t    mode_c;
   logic [N_IO-1:0]       pad_s;
   logic [N_IO-1:0]       pad_o_q;
   logic [N_IO-1:0]       pad_oe_q;
   logic [N_IO-1:0]       core_i_q;

   // trst or power-up reset clears scan side at once; release: two tck
   assign tck_rst_raw_n = i_trst_n & i_resetn;

   always_ff @(posedge i_tck or negedge tck_rst_raw_n) begin
      if (!tck_rst_raw_n) begin
         tck_rst_q <= 2'h0;
      end else begin
         tck_rst_q <= {tck_rst_q[0], 1'h1};
      end
   end
   assign tck_rst_n = tck_rst_q[1];

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         clk_rst_q <= 2'h0;
      end else begin
         clk_rst_q <= {clk_rst_q[0], 1'h1};
      end
   end
   assign clk_rst_n = clk_rst_q[1];

   // pull-ups are fixed on; the pad model resolves undriven pins high
   assign o_pullup_en = bst_pkg::PULLUP_ALL;

   // controller next state from tms
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         bst_pkg::ST_TLR:    st_d = i_tms ? bst_pkg::ST_TLR
                                          : bst_pkg::ST_RTI;
         bst_pkg::ST_RTI:    st_d = i_tms ? bst_pkg::ST_SEL_DR
                                          : bst_pkg::ST_RTI;
         bst_pkg::ST_SEL_DR: st_d = i_tms ? bst_pkg::ST_SEL_IR
                                          : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR: st_d = i_tms ? bst_pkg::ST_EX1_DR
                                          : bst_pkg::ST_SH_DR;
         bst_pkg::ST_SH_DR:  st_d = i_tms ? bst_pkg::ST_EX1_DR
                                          : bst_pkg::ST_SH_DR;
         bst_pkg::ST_EX1_DR: st_d = i_tms ? bst_pkg::ST_UPD_DR
                                          : bst_pkg::ST_PA_DR;
         bst_pkg::ST_PA_DR:  st_d = i_tms ? bst_pkg::ST_EX2_DR
                                          : bst_pkg::ST_PA_DR;
         bst_pkg::ST_EX2_DR: st_d = i_tms ? bst_pkg::ST_UPD_DR
                                          : bst_pkg::ST_SH_DR;
         bst_pkg::ST_UPD_DR: st_d = i_tms ? bst_pkg::ST_SEL_DR
                                          : bst_pkg::ST_RTI;
         bst_pkg::ST_SEL_IR: st_d = i_tms ? bst_pkg::ST_TLR
                                          : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR: st_d = i_tms ? bst_pkg::ST_EX1_IR
                                          : bst_pkg::ST_SH_IR;
         bst_pkg::ST_SH_IR:  st_d = i_tms ? bst_pkg::ST_EX1_IR
                                          : bst_pkg::ST_SH_IR;
         bst_pkg::ST_EX1_IR: st_d = i_tms ? bst_pkg::ST_UPD_IR
                                          : bst_pkg::ST_PA_IR;
         bst_pkg::ST_PA_IR:  st_d = i_tms ? bst_pkg::ST_EX2_IR
                                          : bst_pkg::ST_PA_IR;
         bst_pkg::ST_EX2_IR: st_d = i_tms ? bst_pkg::ST_UPD_IR
                                          : bst_pkg::ST_SH_IR;
         bst_pkg::ST_UPD_IR: st_d = i_tms ? bst_pkg::ST_SEL_DR
                                          : bst_pkg::ST_RTI;
      endcase
   end

   always_ff @(posedge i_tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         st_q <= bst_pkg::ST_TLR;
      end else begin
         st_q <= st_d;
      end
   end

   // instruction shift stage, lsb out first
   always_ff @(posedge i_tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_sr_q <= bst_pkg::IR_CAPTURE;
      end else if (st_q == bst_pkg::ST_CAP_IR) begin
         ir_sr_q <= bst_pkg::IR_CAPTURE;
      end else if (st_q == bst_pkg::ST_SH_IR) begin
         ir_sr_q <= {i_tdi, ir_sr_q[7:1]};
      end
   end

   // active instruction and its pad mode change on the falling edge
   always_ff @(negedge i_tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_q   <= bst_pkg::OP_BYPASS;
         mode_q <= '0;
      end else if (st_q == bst_pkg::ST_TLR) begin
         ir_q   <= bst_pkg::OP_BYPASS;
         mode_q <= '0;
      end else if (st_q == bst_pkg::ST_UPD_IR) begin
         ir_q   <= ir_sr_q;
         mode_q <= bst_pkg::op_mode(ir_sr_q);
      end
   end

   assign dr_sel = bst_pkg::dr_select(ir_q);
   // bypass: one bit, captures zero
   always_ff @(posedge i_tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         byp_q <= 1'h0;
      end else if (dr_sel == bst_pkg::DR_BYP) begin
         if (st_q == bst_pkg::ST_CAP_DR) begin
            byp_q <= 1'h0;
         end else if (st_q == bst_pkg::ST_SH_DR) begin
            byp_q <= i_tdi;
         end
      end
   end

   assign id_value = {ID_VERSION, ID_PART, ID_MFR, bst_pkg::ID_MARKER};
   always_ff @(posedge i_tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         id_sr_q <= '0;
      end else if (dr_sel == bst_pkg::DR_ID) begin
         if (st_q == bst_pkg::ST_CAP_DR) begin
            id_sr_q <= id_value;
         end else if (st_q == bst_pkg::ST_SH_DR) begin
            id_sr_q <= {i_tdi, id_sr_q[31:1]};
         end
      end
   end

   // boundary chain; pins and core values are async to tck
   bst_sync2 #(
      .W (3*N_IO+1)
   ) u_sync_tck (
      .i_clk   (i_tck),
      .i_rst_n (tck_rst_n),
      .i_d     ({i_programmed, i_core_oe, i_core_o, i_pad_i}),
      .o_q     (pi_t)
   );
   assign cap_bsr = st_q == bst_pkg::ST_CAP_DR && dr_sel == bst_pkg::DR_BSR;
   assign sh_bsr  = st_q == bst_pkg::ST_SH_DR  && dr_sel == bst_pkg::DR_BSR;
   assign upd_bsr = st_q == bst_pkg::ST_UPD_DR && dr_sel == bst_pkg::DR_BSR;
   assign chain[0] = i_tdi;
   genvar g;
   generate
      for (g = 0; g < N_IO; g++) begin : g_io
         // disabled input buffers read low while unprogrammed
         assign cell_pi[g*3+bst_pkg::CELL_IN]  =
            pi_t[g] & pi_t[3*N_IO];
         assign cell_pi[g*3+bst_pkg::CELL_OUT] = pi_t[N_IO+g];
         assign cell_pi[g*3+bst_pkg::CELL_OE]  = pi_t[2*N_IO+g];
      end
      for (g = 0; g < NC; g++) begin : g_cell
         bst_bscell u_cell (
            .i_tck     (i_tck),
            .i_rst_n   (tck_rst_n),
            .i_si      (chain[g]),
            .i_pi      (cell_pi[g]),
            .i_capture (cap_bsr),
            .i_shift   (sh_bsr),
            .i_update  (upd_bsr),
            .o_so      (chain[g+1]),
            .o_po      (cell_po[g])
         );
      end
   endgenerate

   always_comb begin
      case (dr_sel)
         bst_pkg::DR_ID:  dr_out = id_sr_q[0];
         bst_pkg::DR_BSR: dr_out = chain[NC];
         default:         dr_out = byp_q;
      endcase
   end

   always_ff @(negedge i_tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tdo_q    <= 1'h0;
         tdo_oe_q <= 1'h0;
      end else begin
         tdo_oe_q <= (st_q == bst_pkg::ST_SH_IR) ||
                     (st_q == bst_pkg::ST_SH_DR);
         if (st_q == bst_pkg::ST_SH_IR) begin
            tdo_q <= ir_sr_q[0];
         end else if (st_q == bst_pkg::ST_SH_DR) begin
            tdo_q <= dr_out;
         end
      end
   end
   assign o_tdo    = tdo_q;
   assign o_tdo_oe = tdo_oe_q;

   // update bits and mode move only at update states and test-logic-reset: per-bit sync is enough
   bst_sync2 #(
      .W (NC+2)
   ) u_sync_upd (
      .i_clk   (i_clk),
      .i_rst_n (clk_rst_n),
      .i_d     ({mode_q, cell_po}),
      .o_q     (upd_c)
   );
   assign upd_cells_c = upd_c[NC-1:0];
   assign mode_c      = upd_c[NC+1:NC];
   bst_sync2 #(
      .W (N_IO)
   ) u_sync_pad (
      .i_clk   (i_clk),
      .i_rst_n (clk_rst_n),
      .i_d     (i_pad_i),
      .o_q     (pad_s)
   );
   always_ff @(posedge i_clk or negedge clk_rst_n) begin
      if (!clk_rst_n) begin
         pad_o_q  <= '0;
         pad_oe_q <= '0;
         core_i_q <= '0;
      end else begin
         for (int k = 0; k < N_IO; k++) begin
            if (!i_programmed) begin
               pad_o_q[k]  <= 1'h0;
               pad_oe_q[k] <= 1'h0;
               core_i_q[k] <= 1'h0;
            end else if (mode_c.hiz) begin
               pad_o_q[k]  <= i_core_o[k];
               pad_oe_q[k] <= 1'h0;
               core_i_q[k] <= pad_s[k];
            end else if (mode_c.drive) begin
               pad_o_q[k]  <= upd_cells_c[k*3+bst_pkg::CELL_OUT];
               pad_oe_q[k] <= upd_cells_c[k*3+bst_pkg::CELL_OE];
               core_i_q[k] <= upd_cells_c[k*3+bst_pkg::CELL_IN];
            end else begin
               pad_o_q[k]  <= i_core_o[k];
               pad_oe_q[k] <= i_core_oe[k];
               core_i_q[k] <= pad_s[k];
            end
         end
      end
   end
   assign o_pad_o  = pad_o_q;
   assign o_pad_oe = pad_oe_q;
   assign o_core_i = core_i_q;

   sequence s_ir_capture;
      st_q == bst_pkg::ST_CAP_IR;
   endsequence
   sequence s_id_capture;
      (st_q == bst_pkg::ST_CAP_DR) && (dr_sel == bst_pkg::DR_ID);
   endsequence
   sequence s_bypass_shift;
      (st_q == bst_pkg::ST_SH_DR) && (dr_sel == bst_pkg::DR_BYP)
      ##1 (st_q == bst_pkg::ST_SH_DR);
   endsequence
   a_tms_five_reset: assert property (
      @(posedge i_tck) disable iff (!tck_rst_n)
      i_tms [*5] |=> st_q == bst_pkg::ST_TLR)
      else $error("five tms highs did not reach reset");
   a_ir_reset_bypass: assert property (
      @(posedge i_tck) disable iff (!tck_rst_n)
      (st_q == bst_pkg::ST_TLR) ##1 (st_q == bst_pkg::ST_TLR)
      |-> ir_q == bst_pkg::OP_BYPASS)
      else $error("instruction not bypass in reset state");
   a_ir_capture_code: assert property (
      @(posedge i_tck) disable iff (!tck_rst_n)
      s_ir_capture |=> ir_sr_q == bst_pkg::IR_CAPTURE)
      else $error("instruction capture value wrong");
   a_unknown_op_bypass: assert property (
      @(posedge i_tck) disable iff (!tck_rst_n)
      (ir_q != bst_pkg::OP_EXTEST) && (ir_q != bst_pkg::OP_SAMPLE) &&
      (ir_q != bst_pkg::OP_IDCODE) |-> dr_sel == bst_pkg::DR_BYP)
      else $error("undefined opcode did not select bypass");
   a_bypass_one_bit: assert property (
      @(posedge i_tck) disable iff (!tck_rst_n)
      s_bypass_shift |-> o_tdo == $past(i_tdi))
      else $error("bypass path is not one stage");
   a_idcode_capture: assert property (
      @(posedge i_tck) disable iff (!tck_rst_n)
      s_id_capture |=> (id_sr_q == id_value) && id_sr_q[0])
      else $error("identification capture wrong");
   a_tdo_shift_only: assert property (
      @(posedge i_tck) disable iff (!tck_rst_n)
      $stable(st_q) |-> o_tdo_oe == ((st_q == bst_pkg::ST_SH_IR) ||
                                     (st_q == bst_pkg::ST_SH_DR)))
      else $error("tdo enable outside shift states");
   a_shift_dr_hold: assert property (
      @(posedge i_tck) disable iff (!tck_rst_n)
      (st_q == bst_pkg::ST_SH_DR) && !i_tms |=> st_q == bst_pkg::ST_SH_DR)
      else $error("shift state left with tms low");
   a_highz_pads_off: assert property (
      @(posedge i_clk) disable iff (!clk_rst_n)
      mode_c.hiz && i_programmed |=> o_pad_oe == '0)
      else $error("pads driven under highz");
   a_unprog_pads_off: assert property (
      @(posedge i_clk) disable iff (!clk_rst_n)
      !i_programmed |=> (o_pad_oe == '0) && (o_core_i == '0))
      else $error("pads active while unprogrammed");
endmodule : bst_tap_top

// [bst_host_model.sv]
// behavioural scan tester that drives the test port pins
`timescale 1ns/1ps
module bst_host_model (
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   output logic o_trst_n,
   input  logic i_tdo
);
   // tck stands low between frames, so each task makes its own edges
   initial begin
      o_tck    = 1'b0;
      o_tms    = 1'b1;
      o_tdi    = 1'b1;
      o_trst_n = 1'b1;
   end

   task automatic tick(input logic tms, input logic tdi,
                       output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      #16;
      tdo   = i_tdo;
      o_tck = 1'b1;
      #16;
      o_tck = 1'b0;
   endtask : tick

   task automatic idle(input int n, input logic tms);
      logic d;
      repeat (n) tick(tms, 1'b1, d);
   endtask : idle

   task automatic tms_reset();
      idle(5, 1'b1);
      idle(1, 1'b0);
   endtask : tms_reset

   // only two high edges: without trst the machine ends elsewhere
   task automatic trst_pulse();
      o_trst_n = 1'b0;
      #40;
      o_trst_n = 1'b1;
      idle(2, 1'b1);
      idle(1, 1'b0);
   endtask : trst_pulse

   // from idle: select, capture, shift n bits lsb first, update, idle
   task automatic scan(input logic ir, input int n,
                       input logic [31:0] din, output logic [31:0] dout);
      logic d;
      dout = '0;
      tick(1'b1, 1'b1, d);
      if (ir)
         tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
      tick(1'b0, 1'b1, d);
      for (int i = 0; i < n; i++)
         tick(i == n - 1, din[i], dout[i]);
      tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
   endtask : scan
endmodule : bst_host_model

// [bst_tap_top_tb_top.sv]
// self-checking bench for the boundary scan port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   error_cnt++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module bst_tap_top_tb_top;
   localparam logic [3:0]  VER  = 4'h3;     // arbitrary value
   localparam logic [15:0] PART = 16'h0c0d; // arbitrary value
   localparam logic [10:0] MFR  = 11'h123;  // arbitrary value
   logic        i_clk, i_resetn, tck, tms, tdi, trst_n, tdo, tdo_oe, prog;
   logic        tdo_pin;
   logic [2:0]  pull;
   logic [7:0]  core_o, core_oe, core_i, pad_i, pad_o, pad_oe;
   logic [31:0] rx;
   logic [23:0] c, v;
   int          error_cnt, checks_done;

   // tdo has no pull: a released pin is modelled as the inverse value
   assign tdo_pin = tdo_oe ? tdo : ~tdo;
   bst_host_model host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
      .o_trst_n(trst_n), .i_tdo(tdo_pin));
   bst_tap_top #(.N_IO(8), .ID_VERSION(VER), .ID_PART(PART),
      .ID_MFR(MFR)) dut (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_tck(tck), .i_tms(tms),
      .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
      .o_pullup_en(pull), .i_programmed(prog), .i_core_o(core_o),
      .i_core_oe(core_oe), .o_core_i(core_i), .i_pad_i(pad_i),
      .o_pad_o(pad_o), .o_pad_oe(pad_oe));

   initial i_clk = 1'b0;
   always #12.5 i_clk = ~i_clk;

   function automatic logic [23:0] rev(input logic [23:0] x);
      for (int i = 0; i < 24; i++)
         rev[i] = x[23 - i];
   endfunction : rev

   task automatic wclk(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask : wclk

   task automatic ir(input logic [7:0] op);
      host.scan(1'b1, 8, {24'h0, op}, rx);
      `CHK("ir_capture", bst_pkg::IR_CAPTURE, rx[7:0])
   endtask : ir

   // bypass captures 0, then shows the first bit shifted in
   task automatic dr2();
      host.scan(1'b0, 2, 32'h3, rx);
      `CHK("bypass", 2'h2, rx[1:0])
      `CHK("tdo_oe", 1'b0, tdo_oe)
   endtask : dr2

   task automatic wrap_up();
      if (error_cnt == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task automatic t_powerup();
      host.idle(2, 1'b1);
      host.idle(1, 1'b0);
      dr2();
      `CHK("pullups", 3'h7, pull)
   endtask : t_powerup

   task automatic t_idcode();
      ir(bst_pkg::OP_IDCODE);
      host.scan(1'b0, 32, 32'h0, rx);
      `CHK("idcode", {VER, PART, MFR, bst_pkg::ID_MARKER}, rx)
   endtask : t_idcode

   task automatic t_decode();
      logic [7:0] ops [5];
      ops = '{bst_pkg::OP_USER, bst_pkg::OP_CLAMP, bst_pkg::OP_HIGHZ,
              8'h3c, bst_pkg::OP_BYPASS};
      foreach (ops[i]) begin
         ir(ops[i]);
         dr2();
      end
   endtask : t_decode

   task automatic t_resets();
      ir(bst_pkg::OP_IDCODE);
      host.tms_reset();
      dr2();
      ir(bst_pkg::OP_IDCODE);
      host.trst_pulse();
      dr2();
   endtask : t_resets

   task automatic t_bsr();
      for (int k = 0; k < 8; k++) begin
         c[3*k]   = pad_i[k];
         c[3*k+1] = core_o[k];
         c[3*k+2] = core_oe[k];
         v[3*k]   = k[1];
         v[3*k+1] = k[0];
         v[3*k+2] = (k < 4);
      end
      ir(bst_pkg::OP_SAMPLE);
      host.scan(1'b0, 24, {8'h0, rev(v)}, rx);
      `CHK("bsr_capture", rev(c), rx[23:0])
      wclk(8);
      `CHK("sample_pads", core_o, pad_o)
      ir(bst_pkg::OP_EXTEST);
      wclk(8);
      `CHK("extest_o", 8'haa, pad_o)
      `CHK("extest_oe", 8'h0f, pad_oe)
      `CHK("extest_in", 8'hcc, core_i)
      ir(bst_pkg::OP_CLAMP);
      wclk(8);
      `CHK("clamp_o", 8'haa, pad_o)
      ir(bst_pkg::OP_HIGHZ);
      wclk(8);
      `CHK("highz_oe", 8'h00, pad_oe)
   endtask : t_bsr

   task automatic t_unprog();
      wclk(1);
      prog = 1'b0;
      ir(bst_pkg::OP_SAMPLE);
      host.scan(1'b0, 24, 32'hffffff, rx);
      `CHK("unprog_cap", rev(c & 24'hdb6db6), rx[23:0])
      wclk(8);
      `CHK("unprog_oe", 8'h00, pad_oe)
      `CHK("unprog_in", 8'h00, core_i)
      prog = 1'b1;
      ir(bst_pkg::OP_BYPASS);
      wclk(8);
      `CHK("normal_oe", core_oe, pad_oe)
      `CHK("normal_in", pad_i, core_i)
   endtask : t_unprog

   initial begin
      i_resetn = 1'b0;
      prog     = 1'b1;
      core_o   = 8'hc3;
      core_oe  = 8'h3c;
      pad_i    = 8'h5a;
      wclk(2);
      i_resetn = 1'b1;
      wclk(4);
      t_powerup();
      t_idcode();
      t_decode();
      t_resets();
      t_bsr();
      t_unprog();
      wrap_up();
   end

   // whole run needs under 60 us of scan traffic
   initial begin
      #400000;
      error_cnt++;
      wrap_up();
   end
endmodule : bst_tap_top_tb_top
